// >>> include/mcam_pkg.sv
package mcam_pkg;

    // Dual-port RAM geometry: byte addresses, stored as 32-bit words.
    localparam int          DPR_AW          = 13;
    localparam int          DPR_WORDS       = 2048;

    // Controller parameter areas and the global parameters inside them.
    localparam int          CTRL_AREA_SHIFT = 8;
    localparam logic [7:0]  GLOBAL_BYTES    = 8'hAF;
    localparam logic [12:0] OFS_DESC_BASE   = 13'h0000;
    localparam logic [12:0] OFS_STATE       = 13'h0004;
    localparam logic [12:0] OFS_TX_START    = 13'h0008;
    localparam logic [12:0] OFS_RX_CUR      = 13'h000A;
    localparam logic [12:0] OFS_RX_START    = 13'h0018;
    localparam logic [15:0] STATE_INIT      = 16'h8000;
    localparam logic [7:0]  RX_TABLE_OFS    = 8'h20;
    localparam logic [7:0]  TX_TABLE_OFS    = 8'h60;

    // Per-channel parameter block; receive half low, transmit half high.
    localparam int          CHAN_SHIFT      = 6;
    localparam logic [12:0] CH_OFS_RING     = 13'h0000;
    localparam logic [12:0] CH_OFS_CUR      = 13'h0004;
    localparam logic [12:0] CH_OFS_LEN      = 13'h0008;

    // Slot mapping entry layout.
    localparam int          ENT_VALID_BIT   = 31;
    localparam int          ENT_MASK_HI     = 29;
    localparam int          ENT_MASK_LO     = 16;
    localparam int          ENT_CHAN_HI     = 11;
    localparam int          ENT_CHAN_LO     = 6;

    // Descriptor geometry in external memory; slot table step in the RAM.
    localparam logic [15:0] BD_BYTES        = 16'h0008;
    localparam logic [31:0] BD_PTR_OFS      = 32'h0000_0004;
    localparam logic [15:0] TBL_STEP        = 16'h0004;

    typedef enum logic {DIR_RX, DIR_TX} mcam_dir_t;

    typedef struct packed {
        logic       frame_start;
        mcam_dir_t  dir;
    } mcam_slot_t;

    typedef struct packed {
        logic        we;
        logic [3:0]  wstrb;
        logic [12:0] addr;
        logic [31:0] wdata;
    } mcam_host_t;

    typedef struct packed {
        mcam_dir_t   dir;
        logic [5:0]  channel;
        logic [13:0] sub_mask;
        logic [15:0] bd_status;
        logic [15:0] length;
        logic [31:0] bd_addr;
        logic [31:0] buf_addr;
    } mcam_xfer_t;

    // Word index of a byte address.
    function automatic logic [10:0] word_of(input logic [12:0] addr);
        return addr[12:2];
    endfunction

    // Halfword picked out of a word by byte address bit 1.
    function automatic logic [15:0] half_of(input logic [31:0] w, input logic hi);
        return hi ? w[31:16] : w[15:0];
    endfunction

    // Byte enables for a halfword write.
    function automatic logic [3:0] half_be(input logic [12:0] addr);
        return addr[1] ? 4'h0C : 4'h03;
    endfunction

endpackage

// >>> core/mcam_dpram.sv
`timescale 1ns/1ps
// Two-port word memory with byte enables; both read ports are registered.
module mcam_dpram (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        a_en,
    input  wire logic [3:0]  a_be,
    input  wire logic [10:0] a_addr,
    input  wire logic [31:0] a_wdata,
    output logic      [31:0] a_rdata,
    input  wire logic        b_en,
    input  wire logic [3:0]  b_be,
    input  wire logic [10:0] b_addr,
    input  wire logic [31:0] b_wdata,
    output logic      [31:0] b_rdata
);
    import mcam_pkg::*;

    logic [31:0] mem [DPR_WORDS];

    // Array writes carry no reset so the array maps onto RAM cells.
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (a_en && a_be[i]) begin
                mem[a_addr][8*i +: 8] <= a_wdata[8*i +: 8];
            end
            if (b_en && b_be[i]) begin
                mem[b_addr][8*i +: 8] <= b_wdata[8*i +: 8];
            end
        end
    end

    // Read data registers; a same-cycle write returns the old word.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            a_rdata <= 32'h0000_0000;
            b_rdata <= 32'h0000_0000;
        end else begin
            a_rdata <= mem[a_addr];
            b_rdata <= mem[b_addr];
        end
    end

endmodule

// >>> core/mcam_engine.sv
`timescale 1ns/1ps
module mcam_engine (
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    input  wire logic [1:0]           ctrl_sel,
    input  wire logic                 slot_valid,
    input  wire mcam_pkg::mcam_slot_t slot_req,
    output logic                      slot_ready,
    input  wire logic                 hp_valid,
    input  wire mcam_pkg::mcam_host_t hp_req,
    output logic      [31:0]          hp_rdata,
    output logic                      hp_rvalid,
    output logic                      ext_req,
    output logic      [31:0]          ext_addr,
    input  wire logic                 ext_ack,
    input  wire logic [31:0]          ext_rdata,
    output logic                      slot_mapped,
    output logic                      slot_skipped,
    output logic                      xfer_valid,
    output mcam_pkg::mcam_xfer_t      xfer,
    output logic      [15:0]          rx_current_slot_pointer,
    output logic      [15:0]          tx_current_slot_pointer
);
    import mcam_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_START_RD, ST_START_WT, ST_ENT_RD, ST_ENT_WT,
        ST_RING_RD, ST_RING_WT, ST_CUR_RD, ST_CUR_WT, ST_LEN_RD, ST_LEN_WT,
        ST_BASE_RD, ST_BASE_WT, ST_BD0, ST_BD1, ST_DONE
    } mcam_state_t;

    mcam_state_t state;
    mcam_state_t next_state;
    logic        frame_q;
    mcam_dir_t   dir_q;
    logic [1:0]  ctrl_q;
    logic        rd_hi;
    logic [15:0] ring_start;
    logic [15:0] cur_ofs;
    logic [15:0] ring_len;

    // Engine side of the parameter RAM.
    logic        b_en;
    logic [3:0]  b_be;
    logic [12:0] b_addr;
    logic [31:0] b_wdata;
    logic [31:0] b_rdata;
    logic [15:0] rd_half;

    // Address arithmetic shared by the sequencer.
    wire  [12:0] area_base  = {3'b000, ctrl_q, 8'h00};
    wire  [12:0] dir_half   = {11'h000, dir_q == DIR_TX, 1'b0};
    wire  [12:0] chan_base  = {1'b0, xfer.channel, 6'b00_0000};
    wire  [15:0] cur_slot   = (dir_q == DIR_TX) ? tx_current_slot_pointer
                                                : rx_current_slot_pointer;
    wire  [15:0] next_slot  = 16'(cur_slot + TBL_STEP);
    wire  [15:0] ring_end   = 16'(ring_start + {ring_len[12:0], 3'b000});
    wire  [15:0] bd_step    = 16'(cur_ofs + BD_BYTES);
    wire  [15:0] next_cur   = (bd_step >= ring_end) ? ring_start : bd_step;
    wire  [31:0] bd_addr_w  = b_rdata + {16'h0000, cur_ofs};
    wire         ent_valid  = b_rdata[ENT_VALID_BIT];
    wire         in_bd      = (state == ST_BD0) || (state == ST_BD1);

    assign rd_half      = half_of(b_rdata, rd_hi);
    assign slot_ready   = (state == ST_IDLE);
    assign slot_mapped  = (state == ST_RING_RD);
    assign xfer_valid   = (state == ST_DONE);
    assign ext_req      = in_bd;

    // Engine RAM address per state; pointers are offsets from the RAM base.
    always_comb begin
        case (state)
            ST_START_RD: b_addr = area_base + ((dir_q == DIR_TX) ? OFS_TX_START
                                                                 : OFS_RX_START);
            ST_ENT_RD:   b_addr = cur_slot[12:0];
            ST_ENT_WT:   b_addr = area_base + OFS_RX_CUR;
            ST_RING_RD:  b_addr = chan_base + CH_OFS_RING + dir_half;
            ST_CUR_RD:   b_addr = chan_base + CH_OFS_CUR + dir_half;
            ST_LEN_RD:   b_addr = chan_base + CH_OFS_LEN + dir_half;
            ST_BASE_RD:  b_addr = area_base + OFS_DESC_BASE;
            ST_BASE_WT:  b_addr = chan_base + CH_OFS_CUR + dir_half;
            default:     b_addr = 13'h0000;
        endcase
    end

    // Write-backs: the receive slot pointer after each entry, the ring
    // position before the two descriptor reads. Halfword strobes keep the
    // neighbouring field intact.
    always_comb begin
        b_en    = 1'b0;
        b_be    = 4'h0;
        b_wdata = 32'h0000_0000;
        if (state == ST_ENT_WT && dir_q == DIR_RX) begin
            b_en    = 1'b1;
            b_be    = half_be(b_addr);
            b_wdata = {next_slot, next_slot};
        end else if (state == ST_BASE_WT) begin
            b_en    = 1'b1;
            b_be    = half_be(b_addr);
            b_wdata = {next_cur, next_cur};
        end
    end

    // Sequencer: table entry, channel block, base, then two descriptor words.
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (slot_valid) begin
                    next_state = slot_req.frame_start ? ST_START_RD : ST_ENT_RD;
                end
            end
            ST_START_RD: next_state = ST_START_WT;
            ST_START_WT: next_state = ST_ENT_RD;
            ST_ENT_RD:   next_state = ST_ENT_WT;
            ST_ENT_WT:   next_state = ent_valid ? ST_RING_RD : ST_IDLE;
            ST_RING_RD:  next_state = ST_RING_WT;
            ST_RING_WT:  next_state = ST_CUR_RD;
            ST_CUR_RD:   next_state = ST_CUR_WT;
            ST_CUR_WT:   next_state = ST_LEN_RD;
            ST_LEN_RD:   next_state = ST_LEN_WT;
            ST_LEN_WT:   next_state = ST_BASE_RD;
            ST_BASE_RD:  next_state = ST_BASE_WT;
            ST_BASE_WT:  next_state = ST_BD0;
            ST_BD0: begin
                if (ext_ack) begin
                    next_state = ST_BD1;
                end
            end
            ST_BD1: begin
                if (ext_ack) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE:     next_state = ST_IDLE;
            default:     next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Request capture; the controller is held for the whole slot so a
    // change on ctrl_sel mid-lookup cannot mix two parameter areas.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frame_q <= 1'b0;
            dir_q   <= DIR_RX;
            ctrl_q  <= 2'b00;
            rd_hi   <= 1'b0;
        end else begin
            rd_hi <= b_addr[1];
            if (state == ST_IDLE && slot_valid) begin
                frame_q <= slot_req.frame_start;
                dir_q   <= slot_req.dir;
                ctrl_q  <= ctrl_sel;
            end
        end
    end

    // Current slot pointers reload at a frame start and step one entry
    // after each processed slot, invalid entries included.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_current_slot_pointer <= 16'h0000;
            tx_current_slot_pointer <= 16'h0000;
        end else if (state == ST_START_WT) begin
            if (dir_q == DIR_TX) begin
                tx_current_slot_pointer <= rd_half;
            end else begin
                rx_current_slot_pointer <= rd_half;
            end
        end else if (state == ST_ENT_WT) begin
            if (dir_q == DIR_TX) begin
                tx_current_slot_pointer <= next_slot;
            end else begin
                rx_current_slot_pointer <= next_slot;
            end
        end
    end

    // Channel ring parameters from the shared per-channel block.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ring_start <= 16'h0000;
            cur_ofs    <= 16'h0000;
            ring_len   <= 16'h0000;
        end else begin
            if (state == ST_RING_WT) begin
                ring_start <= rd_half;
            end
            if (state == ST_CUR_WT) begin
                cur_ofs <= rd_half;
            end
            if (state == ST_LEN_WT) begin
                ring_len <= rd_half;
            end
        end
    end

    // Result record and external descriptor address.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            xfer     <= '0;
            ext_addr <= 32'h0000_0000;
        end else begin
            case (state)
                ST_ENT_WT: begin
                    // Slots sharing a channel pointer land on one channel.
                    xfer.dir      <= dir_q;
                    xfer.channel  <= b_rdata[ENT_CHAN_HI:ENT_CHAN_LO];
                    xfer.sub_mask <= b_rdata[ENT_MASK_HI:ENT_MASK_LO];
                end
                ST_BASE_WT: begin
                    xfer.bd_addr <= bd_addr_w;
                    ext_addr     <= bd_addr_w;
                end
                ST_BD0: begin
                    if (ext_ack) begin
                        xfer.bd_status <= ext_rdata[31:16];
                        xfer.length    <= ext_rdata[15:0];
                        ext_addr       <= xfer.bd_addr + BD_PTR_OFS;
                    end
                end
                ST_BD1: begin
                    if (ext_ack) begin
                        xfer.buf_addr <= ext_rdata;
                    end
                end
                default: begin
                    xfer.dir <= xfer.dir;
                end
            endcase
        end
    end

    // Skipped slots are flagged for one cycle so the link side idles them.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            slot_skipped <= 1'b0;
        end else begin
            slot_skipped <= (state == ST_ENT_WT) && !ent_valid;
        end
    end

    // Host reads come back one cycle after the request.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hp_rvalid <= 1'b0;
        end else begin
            hp_rvalid <= hp_valid && !hp_req.we;
        end
    end

    mcam_dpram u_ram (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .a_en    (hp_valid && hp_req.we),
        .a_be    (hp_req.wstrb),
        .a_addr  (word_of(hp_req.addr)),
        .a_wdata (hp_req.wdata),
        .a_rdata (hp_rdata),
        .b_en    (b_en),
        .b_be    (b_be),
        .b_addr  (word_of(b_addr)),
        .b_wdata (b_wdata),
        .b_rdata (b_rdata)
    );

endmodule

// >>> test/mcam_ext_mem.sv
`timescale 1ns/1ps
// External descriptor memory; each word is a fixed function of its address.
module mcam_ext_mem (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        slow,
    input  wire logic        ext_req,
    input  wire logic [31:0] ext_addr,
    output logic             ext_ack,
    output logic      [31:0] ext_rdata
);
    logic [2:0]  wait_cnt;
    logic [31:0] last_data;
    // Word 0 is status and length, word 1 the buffer pointer.
    wire logic [31:0] word_val = ext_addr[2] ? (ext_addr ^ 32'hA5A5_0000)
                                             : {16'h9000, ext_addr[15:0]};
    // Slow mode stalls three cycles; a released bus shows the inverse of the last word.
    assign ext_ack = ext_req && (wait_cnt == (slow ? 3'h3 : 3'h0));
    assign ext_rdata = ext_ack ? word_val : ~last_data;
    // Stall counter and remembered data.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wait_cnt <= 3'h0;
            last_data <= 32'h0000_0000;
        end else if (ext_ack) begin
            wait_cnt <= 3'h0;
            last_data <= word_val;
        end else if (ext_req) begin
            wait_cnt <= wait_cnt + 3'h1;
        end
    end
endmodule

// >>> test/mcam_engine_chk.sv
`timescale 1ns/1ps
// Timing relations between slot requests, descriptor reads and results.
module mcam_engine_chk (
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    input  wire logic                 slot_valid,
    input  wire mcam_pkg::mcam_slot_t slot_req,
    input  wire logic                 slot_ready,
    input  wire logic                 hp_valid,
    input  wire mcam_pkg::mcam_host_t hp_req,
    input  wire logic                 hp_rvalid,
    input  wire logic                 ext_req,
    input  wire logic [31:0]          ext_addr,
    input  wire logic                 ext_ack,
    input  wire logic [31:0]          ext_rdata,
    input  wire logic                 slot_mapped,
    input  wire logic                 slot_skipped,
    input  wire logic                 xfer_valid,
    input  wire mcam_pkg::mcam_xfer_t xfer,
    input  wire logic [15:0]          rx_current_slot_pointer
);
    import mcam_pkg::*;
    logic        odd_ack;
    logic [31:0] bd_first;
    logic [31:0] word0;
    wire logic   take = slot_valid && slot_ready;
    // Pairs the two descriptor reads; reset restarts the pairing.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            odd_ack <= 1'b0;
            bd_first <= 32'h0000_0000;
            word0 <= 32'h0000_0000;
        end else if (ext_req && ext_ack) begin
            odd_ack <= !odd_ack;
            if (!odd_ack) begin
                bd_first <= ext_addr;
                word0 <= ext_rdata;
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_first_ack;
        ext_req && ext_ack && !odd_ack;
    endsequence
    sequence s_second_read;
        ext_req && (ext_addr == $past(ext_addr) + 32'h0000_0004);
    endsequence
    a_bd_word_step: assert property (s_first_ack |=> s_second_read)
        else $error("second descriptor read not at next word");
    a_ext_hold: assert property (ext_req && !ext_ack |=> ext_req && $stable(ext_addr))
        else $error("external request dropped or moved before ack");
    a_xfer_after: assert property (ext_req && ext_ack && odd_ack |=> xfer_valid)
        else $error("result missing after second descriptor word");
    a_bd_addr: assert property (xfer_valid |-> xfer.bd_addr == bd_first)
        else $error("result descriptor address differs from fetch");
    a_buf_len: assert property (xfer_valid |-> xfer.buf_addr == $past(ext_rdata)
        && xfer.length == word0[15:0])
        else $error("buffer pointer or length not from descriptor");
    a_skip_time: assert property (slot_skipped |-> $past(take && !slot_req.frame_start, 3)
        || $past(take && slot_req.frame_start, 5))
        else $error("skip pulse at wrong distance from slot");
    a_map_lead: assert property (slot_mapped |-> ##8 ext_req)
        else $error("descriptor read not started after mapping");
    a_rx_step: assert property (take && !slot_req.frame_start && slot_req.dir == DIR_RX
        |-> ##3 rx_current_slot_pointer == $past(rx_current_slot_pointer, 3) + 16'h0004)
        else $error("receive slot pointer did not advance one entry");
    a_rx_hold: assert property (take && slot_req.dir == DIR_TX
        |=> $stable(rx_current_slot_pointer) [*8])
        else $error("transmit slot moved receive pointer");
    a_host_rd: assert property (hp_valid && !hp_req.we |=> hp_rvalid)
        else $error("host read not answered next cycle");
endmodule

// >>> test/mcam_engine_tb.sv
`timescale 1ns/1ps
// Bench: host port loads the tables, slots run against the external memory model.
module mcam_engine_tb;
    import mcam_pkg::*;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [1:0]  ctrl_sel = 2'h0;
    logic        slot_valid = 1'b0;
    mcam_slot_t  slot_req = '0;
    logic        hp_valid = 1'b0;
    mcam_host_t  hp_req = '0;
    logic        slow = 1'b0;
    logic        slot_ready, hp_rvalid, ext_req, ext_ack, slot_skipped, xfer_valid;
    logic [31:0] hp_rdata, ext_addr, ext_rdata;
    mcam_xfer_t  xfer;
    logic [15:0] rx_current_slot_pointer, tx_current_slot_pointer;
    int          num_errors = 0;
    int          num_checks = 0;
    always #20 sys_clk = ~sys_clk;
    mcam_engine dut_u (.sys_clk(sys_clk), .nrst(nrst), .ctrl_sel(ctrl_sel),
        .slot_valid(slot_valid), .slot_req(slot_req), .slot_ready(slot_ready),
        .hp_valid(hp_valid), .hp_req(hp_req), .hp_rdata(hp_rdata), .hp_rvalid(hp_rvalid),
        .ext_req(ext_req), .ext_addr(ext_addr), .ext_ack(ext_ack), .ext_rdata(ext_rdata),
        .slot_mapped(), .slot_skipped(slot_skipped), .xfer_valid(xfer_valid), .xfer(xfer),
        .rx_current_slot_pointer(rx_current_slot_pointer),
        .tx_current_slot_pointer(tx_current_slot_pointer));
    mcam_ext_mem mem_u (.sys_clk(sys_clk), .nrst(nrst), .slow(slow), .ext_req(ext_req),
        .ext_addr(ext_addr), .ext_ack(ext_ack), .ext_rdata(ext_rdata));
    task automatic stop_test();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic host_acc(input logic we, input logic [12:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hp_valid <= 1'b1;
        hp_req <= '{we: we, wstrb: 4'hF, addr: a, wdata: d};
        @(posedge sys_clk);
        hp_valid <= 1'b0;
    endtask
    task automatic host_rd(input logic [12:0] a, input logic [31:0] e);
        host_acc(1'b0, a, 32'h0000_0000);
        @(negedge sys_clk);
        chk("host read valid", 32'h1, hp_rvalid);
        chk("host read data", e, hp_rdata);
    endtask
    // Takes one slot and waits a bounded time for either answer.
    task automatic run_slot(input logic fs, input mcam_dir_t d, input logic [1:0] cs);
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        slot_valid <= 1'b1;
        slot_req <= '{frame_start: fs, dir: d};
        ctrl_sel <= cs;
        @(posedge sys_clk);
        slot_valid <= 1'b0;
        for (int n = 0; n < 200 && !done; n++) begin
            @(negedge sys_clk);
            done = (xfer_valid === 1'b1) || (slot_skipped === 1'b1);
        end
        chk("slot answered", 32'h1, done);
    endtask
    task automatic chk_xfer(input logic [31:0] bd, input logic [5:0] ch, input logic [13:0] m,
                            input mcam_dir_t d);
        chk("result valid", 32'h1, xfer_valid);
        chk("descriptor address", bd, xfer.bd_addr);
        chk("buffer address", (bd + 32'h0000_0004) ^ 32'hA5A5_0000, xfer.buf_addr);
        chk("length", {16'h0000, bd[15:0]}, xfer.length);
        chk("status", 32'h0000_9000, xfer.bd_status);
        chk("channel", ch, xfer.channel);
        chk("subchannel mask", m, xfer.sub_mask);
        chk("direction", d, xfer.dir);
    endtask
    // Loads both controller areas, tables and channel blocks, then reads all back.
    task automatic t_config();
        logic [12:0] a [19] = '{13'h0000, 13'h0004, 13'h0008, 13'h0018, 13'h0020, 13'h0024,
            13'h0028, 13'h002C, 13'h0600, 13'h0604, 13'h0608, 13'h0100, 13'h0108, 13'h0118,
            13'h0120, 13'h0160, 13'h0640, 13'h0644, 13'h0648};
        logic [31:0] d [19] = '{32'h1234_0000, 32'h0000_8000, 32'h0020_0020, 32'h0000_0020,
            32'h8155_0600, 32'hBFFF_0600, 32'h0000_0600, 32'h8155_0600, 32'h0100_FFE0,
            32'h0100_FFE0, 32'h0004_0002, 32'h5678_0000, 32'h0120_0160, 32'h0000_0120,
            32'h8001_0640, 32'h8001_0640, 32'h0300_0200, 32'h0300_0200, 32'h0001_0001};
        foreach (a[i]) host_acc(1'b1, a[i], d[i]);
        foreach (a[i]) host_rd(a[i], d[i]);
    endtask
    // Receive slots: two concatenated, one invalid, then a ring wrap.
    task automatic t_rx_ring();
        run_slot(1'b1, DIR_RX, 2'h0);
        chk_xfer(32'h1234_FFE0, 6'd24, 14'h0155, DIR_RX);
        chk("rx pointer", 32'h0024, rx_current_slot_pointer);
        run_slot(1'b0, DIR_RX, 2'h0);
        chk_xfer(32'h1234_FFE8, 6'd24, 14'h3FFF, DIR_RX);
        run_slot(1'b0, DIR_RX, 2'h0);
        chk("skipped", 32'h1, slot_skipped);
        chk("rx pointer", 32'h002C, rx_current_slot_pointer);
        run_slot(1'b0, DIR_RX, 2'h0);
        chk_xfer(32'h1234_FFE0, 6'd24, 14'h0155, DIR_RX);
        host_rd(13'h0008, 32'h0030_0020);
    endtask
    // Transmit through the shared table with a stalling memory.
    task automatic t_tx_common();
        slow <= 1'b1;
        run_slot(1'b1, DIR_TX, 2'h0);
        chk_xfer(32'h1234_0100, 6'd24, 14'h0155, DIR_TX);
        chk("tx pointer", 32'h0024, tx_current_slot_pointer);
        chk("rx pointer", 32'h0030, rx_current_slot_pointer);
        run_slot(1'b0, DIR_TX, 2'h0);
        chk_xfer(32'h1234_0108, 6'd24, 14'h3FFF, DIR_TX);
        chk("tx pointer", 32'h0028, tx_current_slot_pointer);
        host_rd(13'h0604, 32'h0110_FFE8);
        slow <= 1'b0;
    endtask
    // Second controller area with its own descriptor base and a transmit table at +0x60.
    task automatic t_second_ctrl();
        run_slot(1'b1, DIR_RX, 2'h1);
        chk_xfer(32'h5678_0200, 6'd25, 14'h0001, DIR_RX);
        chk("rx pointer", 32'h0124, rx_current_slot_pointer);
        run_slot(1'b1, DIR_TX, 2'h1);
        chk_xfer(32'h5678_0300, 6'd25, 14'h0001, DIR_TX);
        chk("tx pointer", 32'h0164, tx_current_slot_pointer);
    endtask
    // Mid-run reset clears the pointers; the parameter RAM keeps its contents.
    task automatic t_reset();
        @(posedge sys_clk);
        nrst <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("reset rx pointer", 32'h0000, rx_current_slot_pointer);
        chk("reset tx pointer", 32'h0000, tx_current_slot_pointer);
        chk("reset ready", 32'h1, slot_ready);
        @(posedge sys_clk);
        nrst <= 1'b1;
        host_rd(13'h0108, 32'h0124_0160);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        t_config();
        t_rx_ring();
        t_tx_common();
        t_second_ctrl();
        t_reset();
        stop_test();
    end
    // Watchdog; the whole run needs well under a thousand cycles.
    initial begin
        #800_000;
        num_errors++;
        stop_test();
    end
endmodule
bind mcam_engine mcam_engine_chk chk_u (.sys_clk(sys_clk), .nrst(nrst),
    .slot_valid(slot_valid), .slot_req(slot_req), .slot_ready(slot_ready),
    .hp_valid(hp_valid), .hp_req(hp_req), .hp_rvalid(hp_rvalid), .ext_req(ext_req),
    .ext_addr(ext_addr), .ext_ack(ext_ack), .ext_rdata(ext_rdata),
    .slot_mapped(slot_mapped), .slot_skipped(slot_skipped), .xfer_valid(xfer_valid), .xfer(xfer),
    .rx_current_slot_pointer(rx_current_slot_pointer));
